//--- inc/cmcd_pkg.sv
// Register map, field positions and encodings of the clock output stage
`default_nettype none
package cmcd_pkg;
    localparam int NUM_REGS = 20;
    localparam logic [7:0] REG_ADDR [NUM_REGS] = '{
        8'h14, 8'h15, 8'h16, 8'h18, 8'h1F, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24,
        8'h25, 8'h26, 8'h27, 8'h28, 8'h29, 8'h2A, 8'h2B, 8'h2C, 8'h38, 8'h47};
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int IDX_MUTE_SUP_A = 0;
    localparam int IDX_MUTE_SUP_B = 1;
    localparam int IDX_MUTE_EN = 2;
    localparam int IDX_MARGIN = 3;
    localparam int IDX_PLL1_POST = 18;
    localparam int IDX_PLL2_POST = 19;
    localparam int CTRL_IDX [8] = '{4, 5, 7, 8, 10, 12, 14, 16};
    localparam int DIV_IDX [6] = '{6, 9, 11, 13, 15, 17};
    localparam int MUX2_SEL_BIT = 7;
    localparam int MUX4_SEL_LSB = 6;
    localparam int POST_DIV_LSB = 2;
    localparam int HCSL_TERM_BIT = 3;
    localparam int CMOS_P_BIT = 3;
    localparam int CMOS_N_BIT = 4;
    localparam int CMOS_N_INPHASE_BIT = 5;
    localparam logic [8:0] POST_DIV_MIN = 9'h002;
    localparam logic [8:0] POST_DIV_MAX = 9'h008;
    localparam logic [8:0] MARGIN_MIN_DIV = 9'h009;
    typedef enum logic [1:0] {
        SRC_PRI = 2'b00, SRC_SEC = 2'b01, SRC_PLL1 = 2'b10, SRC_PLL2 = 2'b11
    } cmcd_src_e;
    typedef enum logic [2:0] {
        FMT_OFF = 3'b000, FMT_LVPECL = 3'b001, FMT_LVDS = 3'b010,
        FMT_CML = 3'b011, FMT_HCSL = 3'b100, FMT_LVCMOS = 3'b101
    } cmcd_fmt_e;
    typedef enum logic [1:0] {
        TAIL_NONE = 2'b00, TAIL_4MA = 2'b01, TAIL_6MA = 2'b10, TAIL_8MA = 2'b11
    } cmcd_tail_e;
endpackage : cmcd_pkg
`default_nettype wire

//--- rtl/cmcd_divider.sv
// Integer clock divider with period-boundary ratio reload
`timescale 1ns/1ps
`default_nettype none
module cmcd_divider #(
    parameter int W = 8
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic src_lvl,
    input wire logic src_rise,
    input wire logic [W:0] div_val,
    input wire logic glitchless,
    output logic out_lvl,
    output logic out_rise
);
    logic [W:0] ratio_q, ratio_d, half, cnt_q, cnt_d;
    logic last, out_q, prev_q;

    // Greater-or-equal so a direct shrink mid-period still wraps
    assign last = src_rise && (cnt_q >= ratio_q - 1'b1);

    always_comb begin
        ratio_d = ratio_q;
        if (!glitchless || last) begin
            ratio_d = div_val;
        end
        cnt_d = cnt_q;
        if (src_rise) begin
            cnt_d = last ? '0 : cnt_q + 1'b1;
        end
        half = (ratio_d + 1'b1) >> 1;
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ratio_q <= (W + 1)'(1);
        end else begin
            ratio_q <= ratio_d;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Divide by one passes the source level, one cycle late
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            out_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            prev_q <= out_q;
            if (ratio_d == (W + 1)'(1)) begin
                out_q <= src_lvl;
            end else if (src_rise) begin
                out_q <= (cnt_d < half);
            end
        end
    end

    assign out_lvl = out_q;
    assign out_rise = out_q & ~prev_q;

    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);

    chk_ratio_boundary: assert property (
        $past(glitchless) && $changed(ratio_q) |-> $past(last))
        else $error("ratio reloaded inside a period");
    chk_ratio_follow: assert property (
        glitchless && last |=> ratio_q == $past(div_val))
        else $error("ratio not reloaded at boundary");
endmodule : cmcd_divider
`default_nettype wire

//--- rtl/cmcd_driver.sv
// Output format stage: pin levels, enables, termination and tail current
`timescale 1ns/1ps
`default_nettype none
module cmcd_driver import cmcd_pkg::*; (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [5:0] ctrl,
    input wire logic clk_lvl,
    input wire logic mute,
    output logic p_o,
    output logic p_oe,
    output logic n_o,
    output logic n_oe,
    output logic term_en,
    output logic [1:0] tail_sel
);
    cmcd_fmt_e fmt;
    logic lvl;
    assign fmt = cmcd_fmt_e'(ctrl[2:0]);
    // Muted output parks static low rather than floating
    assign lvl = clk_lvl & ~mute;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            {p_o, p_oe, n_o, n_oe, term_en} <= 5'h00;
            tail_sel <= TAIL_NONE;
        end else begin
            p_o <= lvl;
            n_o <= ~lvl;
            term_en <= 1'b0;
            tail_sel <= TAIL_NONE;
            case (fmt)
                FMT_LVPECL, FMT_LVDS, FMT_CML: begin
                    {p_oe, n_oe} <= 2'b11;
                    term_en <= 1'b1;
                    tail_sel <= (fmt == FMT_LVDS) ? TAIL_4MA : (fmt == FMT_CML) ? TAIL_6MA : TAIL_8MA;
                end
                FMT_HCSL: begin
                    {p_oe, n_oe} <= 2'b11;
                    term_en <= ctrl[HCSL_TERM_BIT];
                end
                FMT_LVCMOS: begin
                    p_oe <= ctrl[CMOS_P_BIT];
                    n_oe <= ctrl[CMOS_N_BIT];
                    n_o <= ctrl[CMOS_N_INPHASE_BIT] ? lvl : ~lvl & ~mute;
                end
                default: begin
                    {p_oe, n_oe} <= 2'b00;
                end
            endcase
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);

    chk_disable_off: assert property (ctrl == 6'h00 |=> !p_oe && !n_oe)
        else $error("disabled output still driven");
    chk_term_auto: assert property (
        fmt inside {FMT_LVPECL, FMT_LVDS, FMT_CML} |=> term_en && p_oe && n_oe)
        else $error("termination off in ac format");
    chk_tail_sel: assert property (
        fmt == FMT_CML |=> tail_sel == TAIL_6MA)
        else $error("wrong tail current");
    chk_cmos_sides: assert property (
        fmt == FMT_LVCMOS |=> p_oe == $past(ctrl[CMOS_P_BIT]) && n_oe == $past(ctrl[CMOS_N_BIT]))
        else $error("cmos side enables wrong");
    chk_mute_hold: assert property (mute ##1 mute |-> !p_o)
        else $error("muted output toggles");
endmodule : cmcd_driver
`default_nettype wire

//--- rtl/cmcd_top.sv
// Clock output distribution: post dividers, muxes, output dividers, formats
`timescale 1ns/1ps
`default_nettype none
module cmcd_top import cmcd_pkg::*; #(
    parameter int DIV_W = 8
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic vco1_in,
    input wire logic vco2_in,
    input wire logic pri_ref_in,
    input wire logic sec_ref_in,
    input wire logic pri_los_in,
    input wire logic sec_los_in,
    input wire logic pll1_lock_in,
    input wire logic pll2_lock_in,
    output wire logic [7:0] out_p_o,
    output wire logic [7:0] out_p_oe,
    output wire logic [7:0] out_n_o,
    output wire logic [7:0] out_n_oe,
    output wire logic [7:0] out_term_en,
    output wire logic [15:0] out_tail_sel
);
    logic [7:0] pins, pin_s1_q, pin_s2_q, pin_s3_q, pin_rise;
    logic [7:0] regs_q [NUM_REGS];
    logic [4:0] rd_idx, wr_idx;
    logic [DIV_W:0] post1_val, post2_val;
    logic pll1_lvl, pll1_rise, pll2_lvl, pll2_rise;
    logic [3:0] src_lvl, src_rise, src_bad;
    logic [1:0] div_sel [6];
    logic [DIV_W:0] div_val [6];
    logic [5:0] div_glitch, div_margin, div_lvl;
    logic [7:0] drv_clk, drv_mute;

    // Register lookup; NUM_REGS marks an unmapped address
    function automatic logic [4:0] reg_lookup(input logic [7:0] addr);
        logic [4:0] idx;
        idx = 5'(NUM_REGS);
        for (int k = 0; k < NUM_REGS; k++) begin
            if (REG_ADDR[k] == addr) begin
                idx = 5'(k);
            end
        end
        return idx;
    endfunction : reg_lookup

    // Post divider codes beyond the top ratio saturate at the top ratio
    function automatic logic [DIV_W:0] post_ratio(input logic [2:0] code);
        logic [DIV_W:0] r;
        r = (DIV_W + 1)'(code) + POST_DIV_MIN;
        return (r > POST_DIV_MAX) ? POST_DIV_MAX : r;
    endfunction : post_ratio

    // Register value v divides by v + 1, so 0 means 1 and FF means 256
    function automatic logic [DIV_W:0] out_ratio(input logic [7:0] v);
        return (DIV_W + 1)'(v) + (DIV_W + 1)'(1);
    endfunction : out_ratio

    // All clock and status pins are asynchronous to clock
    assign pins = {pll2_lock_in, pll1_lock_in, sec_los_in, pri_los_in,
                   sec_ref_in, pri_ref_in, vco2_in, vco1_in};

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pin_s1_q <= 8'h00;
            pin_s2_q <= 8'h00;
            pin_s3_q <= 8'h00;
        end else begin
            pin_s1_q <= pins;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    assign pin_rise = pin_s2_q & ~pin_s3_q;

    // Register file
    assign wr_idx = reg_lookup(reg_addr);
    assign rd_idx = wr_idx;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            for (int k = 0; k < NUM_REGS; k++) begin
                regs_q[k] <= REG_RESET;
            end
        end else if (reg_wr && wr_idx != 5'(NUM_REGS)) begin
            regs_q[wr_idx] <= reg_wdata;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= (rd_idx == 5'(NUM_REGS)) ? 8'h00 : regs_q[rd_idx];
        end
    end

    // PLL post dividers, reloaded only on their own period boundary
    assign post1_val = post_ratio(regs_q[IDX_PLL1_POST][POST_DIV_LSB +: 3]);
    assign post2_val = post_ratio(regs_q[IDX_PLL2_POST][POST_DIV_LSB +: 3]);

    cmcd_divider #(
        .W(DIV_W)
    ) u_post1 (
        .clock(clock),
        .arst_n(arst_n),
        .src_lvl(pin_s2_q[0]),
        .src_rise(pin_rise[0]),
        .div_val(post1_val),
        .glitchless(1'b1),
        .out_lvl(pll1_lvl),
        .out_rise(pll1_rise)
    );

    cmcd_divider #(
        .W(DIV_W)
    ) u_post2 (
        .clock(clock),
        .arst_n(arst_n),
        .src_lvl(pin_s2_q[1]),
        .src_rise(pin_rise[1]),
        .div_val(post2_val),
        .glitchless(1'b1),
        .out_lvl(pll2_lvl),
        .out_rise(pll2_rise)
    );

    // References are tapped ahead of any doubler, so they leave undoubled
    assign src_lvl = {pll2_lvl, pll1_lvl, pin_s2_q[3], pin_s2_q[2]};
    assign src_rise = {pll2_rise, pll1_rise, pin_rise[3], pin_rise[2]};
    // Invalid source: reference lost or PLL unlocked
    assign src_bad = {~pin_s2_q[7], ~pin_s2_q[6], pin_s2_q[5], pin_s2_q[4]};

    for (genvar d = 0; d < 6; d++) begin : g_div
        if (d < 2) begin : g_pair
            // Two-way mux: PLL1 or PLL2 only
            assign div_sel[d] = {1'b1, regs_q[CTRL_IDX[2 * d]][MUX2_SEL_BIT]};
            assign div_margin[d] = regs_q[IDX_MARGIN][2 * d] | regs_q[IDX_MARGIN][2 * d + 1];
        end else begin : g_single
            assign div_sel[d] = regs_q[CTRL_IDX[d + 2]][MUX4_SEL_LSB +: 2];
            assign div_margin[d] = regs_q[IDX_MARGIN][d + 2];
        end
        assign div_val[d] = out_ratio(regs_q[DIV_IDX[d]]);
        // Small ratios get no margining: change there is immediate
        assign div_glitch[d] = div_margin[d] && (div_val[d] >= MARGIN_MIN_DIV);

        cmcd_divider #(
            .W(DIV_W)
        ) u_out_div (
            .clock(clock),
            .arst_n(arst_n),
            .src_lvl(src_lvl[div_sel[d]]),
            .src_rise(src_rise[div_sel[d]]),
            .div_val(div_val[d]),
            .glitchless(div_glitch[d]),
            .out_lvl(div_lvl[d]),
            .out_rise()
        );
    end

    for (genvar i = 0; i < 8; i++) begin : g_out
        localparam int D = (i < 4) ? (i / 2) : (i - 2);
        // Pairs 0/1 and 2/3 hang on one mux and one divider
        assign drv_clk[i] = div_lvl[D];
        assign drv_mute[i] = regs_q[IDX_MUTE_EN][i] & src_bad[div_sel[D]];

        cmcd_driver u_drv (
            .clock(clock),
            .arst_n(arst_n),
            .ctrl(regs_q[CTRL_IDX[i]][5:0]),
            .clk_lvl(drv_clk[i]),
            .mute(drv_mute[i]),
            .p_o(out_p_o[i]),
            .p_oe(out_p_oe[i]),
            .n_o(out_n_o[i]),
            .n_oe(out_n_oe[i]),
            .term_en(out_term_en[i]),
            .tail_sel(out_tail_sel[2 * i +: 2])
        );
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);

    chk_post_range: assert property (
        post1_val >= POST_DIV_MIN && post1_val <= POST_DIV_MAX
        && post2_val >= POST_DIV_MIN && post2_val <= POST_DIV_MAX)
        else $error("post divider ratio out of range");
    chk_mux_pll_only: assert property (
        div_sel[0][1] && div_sel[1][1])
        else $error("two-way mux picked a reference");
    chk_pair_clock: assert property (
        drv_clk[0] == drv_clk[1] && drv_clk[2] == drv_clk[3])
        else $error("paired outputs diverge");
    chk_div_range: assert property (
        div_val[2] >= 9'h001 && div_val[2] <= 9'h100)
        else $error("divide value out of range");
    chk_margin_gate: assert property (
        div_glitch[3] |-> regs_q[IDX_MARGIN][5] && div_val[3] > 9'h008)
        else $error("margining active on small ratio");
    chk_mute_pick: assert property (
        regs_q[IDX_MUTE_EN][4] && div_sel[2] == SRC_PRI && pin_s2_q[4] |-> drv_mute[4])
        else $error("lost reference not muted");
    chk_read_back: assert property (
        reg_wr && reg_addr == REG_ADDR[IDX_MARGIN] ##1 reg_addr == REG_ADDR[IDX_MARGIN]
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("register readback mismatch");
    chk_ref_undoubled: assert property (
        div_sel[2] == SRC_PRI && div_val[2] == 9'h001 |=> div_lvl[2] == $past(pin_s2_q[2]))
        else $error("reference not passed straight through");
    chk_mute_unlock: assert property (
        regs_q[IDX_MUTE_EN][6] && div_sel[4] == SRC_PLL1 && !pin_s2_q[6] |-> drv_mute[6])
        else $error("unlocked pll not muted");
    chk_off_pins: assert property (
        regs_q[CTRL_IDX[7]][5:0] == 6'h00 |=> !out_p_oe[7] && !out_n_oe[7])
        else $error("disabled output pins driven");

    cov_margin_change: cover property (div_glitch[2] ##1 $changed(div_val[2]));
    cov_ref_mux: cover property (div_sel[3] == SRC_SEC && out_p_oe[5]);
    cov_mute: cover property (drv_mute[0] && out_p_oe[0]);
    cov_lvcmos: cover property (regs_q[CTRL_IDX[6]][2:0] == FMT_LVCMOS);
endmodule : cmcd_top
`default_nettype wire

//--- testbench/cmcd_rx_model.sv
// Downstream clock receiver model: edges, periods and shortest pulses
`timescale 1ns/1ps
`default_nettype none
module cmcd_rx_model (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [7:0] p_o,
    input wire logic [7:0] p_oe,
    input wire logic clr,
    output logic [7:0] line_q,
    output int period [8],
    output int min_pulse [8],
    output int rises [8]
);
    int cyc;
    int last_rise [8];
    int run [8];
    logic [7:0] seen;
    // Undriven pin floats: show a changing pattern, never the last level
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            seen[i] = p_oe[i] ? p_o[i] : cyc[0];
        end
    end
    // First run after a clear is partial, so it is kept out of the minimum
    always_ff @(posedge clock) begin
        cyc <= cyc + 1;
        line_q <= seen;
        for (int i = 0; i < 8; i++) begin
            run[i] <= (seen[i] != line_q[i]) ? 1 : run[i] + 1;
            if (clr || !arst_n) begin
                rises[i] <= 0;
                min_pulse[i] <= 99999;
            end else if (seen[i] != line_q[i]) begin
                if (rises[i] > 0 && run[i] < min_pulse[i]) begin
                    min_pulse[i] <= run[i];
                end
                if (seen[i]) begin
                    rises[i] <= rises[i] + 1;
                    period[i] <= cyc - last_rise[i];
                    last_rise[i] <= cyc;
                end
            end
        end
    end
endmodule : cmcd_rx_model
`default_nettype wire

//--- testbench/test_clock_output_distribution.sv
// Self-checking bench for the clock output distribution block
`timescale 1ns/1ps
`default_nettype none
module test_clock_output_distribution import cmcd_pkg::*;;
    logic clock = 1'h0;
    logic arst_n = 1'h0;
    logic reg_wr = 1'h0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic vco1_in = 1'h0, vco2_in = 1'h0, pri_ref_in = 1'h0, sec_ref_in = 1'h0;
    logic pri_los_in = 1'h0, sec_los_in = 1'h0, pll1_lock_in = 1'h1, pll2_lock_in = 1'h1;
    logic [7:0] out_p_o, out_p_oe, out_n_o, out_n_oe, out_term_en;
    logic [15:0] out_tail_sel;
    logic rx_clr = 1'h0;
    int period [8];
    int min_pulse [8];
    int rises [8];
    int n_errors = 0;
    int cmp_count = 0;
    int tcyc = 0;
    // Source periods in clock cycles, by mux code: primary, secondary, VCO1, VCO2
    int src_per [4] = '{8, 10, 4, 6};
    int pd [2];
    logic [7:0] ctl [8];
    logic [7:0] dv [8];
    logic [7:0] d;

    initial forever #2.5 clock = ~clock;
    always @(posedge clock) begin
        tcyc <= tcyc + 1;
        // Whole-ratio VCOs: integer periods of 4 and 6 clock cycles
        vco1_in <= (tcyc % 4) < 2;
        vco2_in <= (tcyc % 6) < 3;
        pri_ref_in <= (tcyc % 8) < 4;
        sec_ref_in <= (tcyc % 10) < 5;
    end

    cmcd_top i_cmcd_top (.clock(clock), .arst_n(arst_n), .reg_wr(reg_wr), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .vco1_in(vco1_in), .vco2_in(vco2_in),
        .pri_ref_in(pri_ref_in), .sec_ref_in(sec_ref_in), .pri_los_in(pri_los_in),
        .sec_los_in(sec_los_in), .pll1_lock_in(pll1_lock_in), .pll2_lock_in(pll2_lock_in),
        .out_p_o(out_p_o), .out_p_oe(out_p_oe), .out_n_o(out_n_o), .out_n_oe(out_n_oe),
        .out_term_en(out_term_en), .out_tail_sel(out_tail_sel));
    cmcd_rx_model i_cmcd_rx_model (.clock(clock), .arst_n(arst_n), .p_o(out_p_o), .p_oe(out_p_oe),
        .clr(rx_clr), .line_q(), .period(period), .min_pulse(min_pulse), .rises(rises));

    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        cmp_count++;
        if (e !== g) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic cmpn(string nm, int e, int g);
        cmp_count++;
        if (e != g) begin
            n_errors++;
            $display("BAD %s expected %0d seen %0d", nm, e, g);
        end
    endtask : cmpn
    task automatic wr(logic [7:0] a, logic [7:0] v);
        @(posedge clock);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clock);
        reg_wr <= 1'h0;
    endtask : wr
    task automatic rd(logic [7:0] a, output logic [7:0] v);
        @(posedge clock);
        reg_addr <= a;
        repeat (2) @(posedge clock);
        #1 v = reg_rdata;
    endtask : rd
    task automatic idle(int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : idle
    task automatic clr;
        @(posedge clock);
        rx_clr <= 1'h1;
        @(posedge clock);
        rx_clr <= 1'h0;
    endtask : clr
    task automatic done(string nm);
        $display("test %s finished", nm);
    endtask : done
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report

    // Expected {p_oe, n_oe, term_en, tail_sel} for control bits 5:0
    function automatic logic [4:0] fmt_exp(logic [5:0] c);
        case (c[2:0])
            3'h1: return 5'h1F;
            3'h2: return 5'h1D;
            3'h3: return 5'h1E;
            3'h4: return {2'h3, c[3], 2'h0};
            3'h5: return {c[3], c[4], 3'h0};
            default: return 5'h00;
        endcase
    endfunction : fmt_exp
    function automatic int exp_per(int i);
        int s;
        int b;
        s = (i < 4) ? 2 + ctl[i & 6][7] : ctl[i][7:6];
        b = src_per[s];
        if (s >= 2) b = b * pd[s - 2];
        return b * (dv[i] + 1);
    endfunction : exp_per
    task automatic run_freq(logic [2:0] c1, logic [2:0] c2);
        pd[0] = (c1 > 5) ? 8 : c1 + 2;
        pd[1] = (c2 > 5) ? 8 : c2 + 2;
        wr(REG_ADDR[IDX_PLL1_POST], {3'h0, c1, 2'h0});
        wr(REG_ADDR[IDX_PLL2_POST], {3'h0, c2, 2'h0});
        for (int i = 0; i < 8; i++) begin
            wr(REG_ADDR[CTRL_IDX[i]], ctl[i]);
            wr(REG_ADDR[DIV_IDX[i < 4 ? i / 2 : i - 2]], dv[i]);
        end
        clr;
        idle(800);
        for (int i = 0; i < 8; i++) begin
            cmpn("output period", exp_per(i), period[i]);
        end
        repeat (16) begin
            @(negedge clock);
            chk("n pin in phase", out_p_o[5], out_n_o[5]);
            chk("n pin complement", !out_p_o[6], out_n_o[6]);
        end
    endtask : run_freq

    initial begin
        repeat (60000) @(posedge clock);
        n_errors++;
        final_report;
    end

    initial begin
        d = 8'($urandom(32177));
        repeat (8) @(posedge clock);
        arst_n <= 1'h1;
        for (int j = 0; j < NUM_REGS; j++) begin
            rd(REG_ADDR[j], d);
            chk("reset value", REG_RESET, d);
        end
        for (int j = 0; j < NUM_REGS; j++) begin
            dv[0] = 8'($urandom);
            wr(REG_ADDR[j], dv[0]);
            rd(REG_ADDR[j], d);
            chk("register readback", dv[0], d);
        end
        wr(8'h30, 8'hA5);
        rd(8'h30, d);
        chk("unmapped read", 8'h00, d);
        wr(REG_ADDR[IDX_MUTE_EN], 8'h00);
        done("registers");
        for (int f = 0; f < 8; f++) begin
            for (int i = 0; i < 8; i++) begin
                ctl[i] = 8'($urandom);
                ctl[i][2:0] = 3'(f);
                if (f == 0) ctl[i][5:0] = 6'h00;
                wr(REG_ADDR[CTRL_IDX[i]], ctl[i]);
            end
            idle(3);
            for (int i = 0; i < 8; i++) begin
                chk("format pins", fmt_exp(ctl[i][5:0]),
                    {out_p_oe[i], out_n_oe[i], out_term_en[i], out_tail_sel[2 * i +: 2]});
            end
        end
        done("formats");
        for (int r = 0; r < 4; r++) begin
            ctl = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h7D, 8'h9D, 8'hC1};
            ctl[0][7] = 1'($urandom);
            ctl[2][7] = 1'($urandom);
            for (int i = 0; i < 8; i += 2) begin
                dv[i] = 8'($urandom % 4);
                dv[i + 1] = (i < 4) ? dv[i] : 8'($urandom % 4);
            end
            if (r == 0) run_freq(3'h7, 3'h0);
            else run_freq(3'($urandom), 3'($urandom));
        end
        done("frequencies");
        // Pin outputs 0/1 to the PLL that is about to unlock
        wr(REG_ADDR[CTRL_IDX[0]], 8'h01);
        wr(REG_ADDR[IDX_MUTE_SUP_A], 8'hFF);
        wr(REG_ADDR[IDX_MUTE_SUP_B], 8'hFF);
        wr(REG_ADDR[IDX_MUTE_EN], 8'hFF);
        pri_los_in <= 1'h1;
        pll1_lock_in <= 1'h0;
        idle(20);
        clr;
        idle(400);
        cmpn("muted edges", 0, rises[4] + rises[0] + rises[6]);
        chk("muted levels", 4'h4, {out_p_o[4], out_n_o[4], out_p_o[6], out_n_o[6]});
        chk("unmuted running", 1'h1, rises[5] > 1 && rises[7] > 1);
        wr(REG_ADDR[IDX_MUTE_EN], 8'h00);
        clr;
        idle(400);
        chk("mute disabled", 1'h1, rises[4] > 1);
        @(posedge clock);
        pri_los_in <= 1'h0;
        pll1_lock_in <= 1'h1;
        done("muting");
        wr(REG_ADDR[IDX_MARGIN], 8'h10);
        wr(REG_ADDR[DIV_IDX[2]], 8'h08);
        idle(200);
        clr;
        repeat (12) begin
            idle($urandom % 90);
            wr(REG_ADDR[DIV_IDX[2]], 8'h0B);
            idle($urandom % 90);
            wr(REG_ADDR[DIV_IDX[2]], 8'h08);
        end
        wr(REG_ADDR[DIV_IDX[2]], 8'h0B);
        idle(400);
        chk("no runt pulse", 1'h1, min_pulse[4] >= 32);
        cmpn("margined period", 96, period[4]);
        wr(REG_ADDR[DIV_IDX[3]], 8'hFF);
        clr;
        idle(5400);
        cmpn("divide by 256", 2560, period[5]);
        done("margining");
        final_report;
    end
endmodule : test_clock_output_distribution
`default_nettype wire
